// ---- design/fmlc_level_store.sv ----
/*
 * fmlc_level_store: holds the applied margin level of each flash block
 * and resolves the level seen by reads of either block.
 * assumes: writes come only from a command that passed all checks.
 */
`timescale 1ns/100ps
`default_nettype none
module fmlc_level_store (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // update
   input wire logic wr_en,
   input wire logic wr_is_ee,
   input wire logic [2:0] wr_level,
   // applied levels
   output logic [2:0] pf_level,
   output logic [2:0] ee_level
);
   logic [2:0] pf_reg;
   logic [2:0] ee_reg;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pf_reg <= fmlc_pkg::RST_LEVEL;
         ee_reg <= fmlc_pkg::RST_LEVEL;
      end
      else if (wr_en)
      begin
         if (wr_is_ee)
            ee_reg <= wr_level;
         else
            pf_reg <= wr_level;
      end
   end

   // a flash-wide level overrides ee; no way to limit it to program flash
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pf_level <= fmlc_pkg::RST_LEVEL;
         ee_level <= fmlc_pkg::RST_LEVEL;
      end
      else
      begin
         pf_level <= pf_reg;
         ee_level <= (pf_reg != fmlc_pkg::RST_LEVEL) ? pf_reg : ee_reg;
      end
   end
endmodule : fmlc_level_store
`default_nettype wire

// ---- design/fmlc_margin_cmd.sv ----
/*
 * fmlc_margin_cmd: AHB-Lite slave running the two margin level commands.
 * assumes: single word transfers, one clock, software launches by
 * writing 1 to the complete flag bit of the status register.
 */
`timescale 1ns/100ps
`default_nettype none
module fmlc_margin_cmd #(
   parameter int EXEC_CYCLES = fmlc_pkg::EXEC_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // margin levels applied to reads
   output logic [2:0] pf_read_level,
   output logic [2:0] ee_read_level,
   // interrupt
   output logic irq
);
   // refused at elaboration: the execution counter is eight bits wide
   if (EXEC_CYCLES < 1 || EXEC_CYCLES > 255)
   begin : g_bad_exec
      $error("EXEC_CYCLES out of range");
   end

   // bus capture
   logic wr_pend_reg;
   logic rd_pend_reg;
   logic [7:0] addr_reg;
   logic access;
   assign access = hsel && hready && htrans[1];

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end
      else
      begin
         wr_pend_reg <= access && hwrite;
         rd_pend_reg <= access && !hwrite;
         if (access)
            addr_reg <= haddr[7:0];
      end
   end

   // registers
   logic [31:0] p0_reg;
   logic [15:0] p1_reg;
   logic [15:0] p2_reg;
   logic [2:0] idx_reg;
   logic special_reg;
   logic acc_reg;
   logic ccf_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;
   fmlc_pkg::fmlc_state_t state_reg;
   logic [7:0] cnt_reg;
   logic chk_ok_reg;
   logic wr_en;
   logic [2:0] pf_lvl;
   logic [2:0] ee_lvl;
   logic launch;
   logic irq_rd_clear;

   assign launch = wr_pend_reg && addr_reg == fmlc_pkg::OFF_STATUS
      && hwdata[fmlc_pkg::STAT_CCF] && ccf_reg;
   assign irq_rd_clear = rd_pend_reg && addr_reg == fmlc_pkg::OFF_IRQ_STAT;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p0_reg <= fmlc_pkg::RST_ZERO;
         p1_reg <= 16'h0000;
         p2_reg <= 16'h0000;
         idx_reg <= 3'h0;
         special_reg <= 1'b0;
         irq_mask_reg <= 2'h0;
      end
      else if (wr_pend_reg && ccf_reg)
      begin
         // parameters are frozen while a command runs
         case (addr_reg)
            fmlc_pkg::OFF_PARAM0: p0_reg <= hwdata;
            fmlc_pkg::OFF_PARAM1: p1_reg <= hwdata[15:0];
            fmlc_pkg::OFF_PARAM2: p2_reg <= hwdata[15:0];
            fmlc_pkg::OFF_INDEX: idx_reg <= hwdata[2:0];
            fmlc_pkg::OFF_MODE: special_reg <= hwdata[0];
            fmlc_pkg::OFF_IRQ_MASK: irq_mask_reg <= hwdata[1:0];
            default: ;
         endcase
      end
   end

   // address checks
   function automatic logic addr_is_ee(input logic [7:0] hi, input logic [15:0] lo);
      addr_is_ee = hi == fmlc_pkg::EE_HI && lo <= fmlc_pkg::EE_LO_MAX;
   endfunction : addr_is_ee

   function automatic logic addr_is_pf(input logic [7:0] hi);
      addr_is_pf = hi >= fmlc_pkg::PF_HI_MIN && hi <= fmlc_pkg::PF_HI_MAX;
   endfunction : addr_is_pf

   logic [7:0] code;
   logic [7:0] ahi;
   logic is_user;
   logic is_field;
   logic chk_ok;
   assign code = p0_reg[15:8];
   assign ahi = p0_reg[7:0];
   assign is_user = code == fmlc_pkg::CMD_USER;
   assign is_field = code == fmlc_pkg::CMD_FIELD;
   always_comb
   begin
      chk_ok = 1'b1;
      if (idx_reg != fmlc_pkg::IDX_REQ)
         chk_ok = 1'b0;
      if (!(is_user || (is_field && special_reg)))
         chk_ok = 1'b0;
      if (!(addr_is_pf(ahi) || addr_is_ee(ahi, p1_reg)))
         chk_ok = 1'b0;
      if (is_user && p2_reg > fmlc_pkg::LVL_MAX_USER)
         chk_ok = 1'b0;
      if (is_field && p2_reg > fmlc_pkg::LVL_MAX_FIELD)
         chk_ok = 1'b0;
   end

   // command sequencer
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= fmlc_pkg::ST_IDLE;
         cnt_reg <= 8'h00;
         chk_ok_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            fmlc_pkg::ST_IDLE:
               if (launch)
                  state_reg <= fmlc_pkg::ST_CHECK;
            fmlc_pkg::ST_CHECK:
            begin
               chk_ok_reg <= chk_ok;
               cnt_reg <= 8'(EXEC_CYCLES);
               state_reg <= chk_ok ? fmlc_pkg::ST_EXEC : fmlc_pkg::ST_DONE;
            end
            fmlc_pkg::ST_EXEC:
            begin
               cnt_reg <= cnt_reg - 8'h01;
               if (cnt_reg == 8'h01)
                  state_reg <= fmlc_pkg::ST_DONE;
            end
            fmlc_pkg::ST_DONE:
               state_reg <= fmlc_pkg::ST_IDLE;
            default:
               state_reg <= fmlc_pkg::ST_IDLE;
         endcase
      end
   end

   // level written once, on the edge that sets the complete flag; rejected commands skip it
   assign wr_en = state_reg == fmlc_pkg::ST_DONE && chk_ok_reg;

   fmlc_level_store u_store (
      .mclk(mclk),
      .rst_n(rst_n),
      .wr_en(wr_en),
      .wr_is_ee(addr_is_ee(ahi, p1_reg)),
      .wr_level(p2_reg[2:0]),
      .pf_level(pf_lvl),
      .ee_level(ee_lvl)
   );

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pf_read_level <= fmlc_pkg::RST_LEVEL;
         ee_read_level <= fmlc_pkg::RST_LEVEL;
      end
      else
      begin
         pf_read_level <= pf_lvl;
         ee_read_level <= ee_lvl;
      end
   end

   // complete flag: cleared by launch, set on completion
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ccf_reg <= 1'b1;
      else if (state_reg == fmlc_pkg::ST_DONE)
         ccf_reg <= 1'b1;
      else if (launch)
         ccf_reg <= 1'b0;
   end

   // access error: write 1 clears, a failing check sets (set wins)
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         acc_reg <= 1'b0;
      else if (state_reg == fmlc_pkg::ST_CHECK && !chk_ok)
         acc_reg <= 1'b1;
      else if (wr_pend_reg && addr_reg == fmlc_pkg::OFF_STATUS && hwdata[fmlc_pkg::STAT_ACC])
         acc_reg <= 1'b0;
   end

   // interrupt status: read clears, new events win
   logic [1:0] ev;
   assign ev = {state_reg == fmlc_pkg::ST_CHECK && !chk_ok, state_reg == fmlc_pkg::ST_DONE};
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat_reg <= 2'h0;
      else
         irq_stat_reg <= (irq_rd_clear ? 2'h0 : irq_stat_reg) | ev;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |((irq_rd_clear ? 2'h0 : irq_stat_reg) & irq_mask_reg);
   end

   // read data, registered from the address phase
   logic [31:0] status_word;
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[fmlc_pkg::STAT_CCF] = ccf_reg;
      status_word[fmlc_pkg::STAT_ACC] = acc_reg;
      // protection and verify flags never set here
      status_word[fmlc_pkg::STAT_PVIOL] = 1'b0;
      status_word[fmlc_pkg::STAT_VHI] = 1'b0;
      status_word[fmlc_pkg::STAT_VLO] = 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         hrdata <= 32'h0000_0000;
      else if (access && !hwrite)
      begin
         case (haddr[7:0])
            fmlc_pkg::OFF_PARAM0: hrdata <= p0_reg;
            fmlc_pkg::OFF_PARAM1: hrdata <= {16'h0000, p1_reg};
            fmlc_pkg::OFF_PARAM2: hrdata <= {16'h0000, p2_reg};
            fmlc_pkg::OFF_INDEX: hrdata <= {29'h0, idx_reg};
            fmlc_pkg::OFF_STATUS: hrdata <= status_word;
            fmlc_pkg::OFF_MODE: hrdata <= {31'h0, special_reg};
            fmlc_pkg::OFF_MARGIN: hrdata <= {13'h0, ee_lvl, 13'h0, pf_lvl};
            fmlc_pkg::OFF_IRQ_STAT: hrdata <= {30'h0, irq_stat_reg};
            fmlc_pkg::OFF_IRQ_MASK: hrdata <= {30'h0, irq_mask_reg};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // assertions
   sequence s_launch;
      state_reg == fmlc_pkg::ST_IDLE && launch;
   endsequence

   sequence s_reject;
      state_reg == fmlc_pkg::ST_CHECK && !chk_ok;
   endsequence

   a_bad_index: assert property (@(posedge mclk) disable iff (!rst_n)
      state_reg == fmlc_pkg::ST_CHECK && idx_reg != fmlc_pkg::IDX_REQ |=> acc_reg && !chk_ok_reg)
      else $error("bad index not flagged");
   a_field_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      state_reg == fmlc_pkg::ST_CHECK && is_field && !special_reg |=> acc_reg)
      else $error("field command ran in normal mode");
   a_bad_addr: assert property (@(posedge mclk) disable iff (!rst_n)
      state_reg == fmlc_pkg::ST_CHECK && !addr_is_pf(ahi) && !addr_is_ee(ahi, p1_reg) |=> acc_reg)
      else $error("bad address not flagged");
   a_bad_level: assert property (@(posedge mclk) disable iff (!rst_n)
      state_reg == fmlc_pkg::ST_CHECK && (p2_reg > fmlc_pkg::LVL_MAX_FIELD
      || (is_user && p2_reg > fmlc_pkg::LVL_MAX_USER)) |=> acc_reg)
      else $error("bad level not flagged");
   a_cmd_done: assert property (@(posedge mclk) disable iff (!rst_n)
      s_launch |=> !ccf_reg ##[1:260] ccf_reg)
      else $error("complete flag not restored");
   a_level_keep: assert property (@(posedge mclk) disable iff (!rst_n)
      s_reject |=> state_reg == fmlc_pkg::ST_DONE && !wr_en)
      else $error("rejected command wrote level");
   a_pf_both: assert property (@(posedge mclk) disable iff (!rst_n)
      pf_lvl != 3'h0 |-> ee_lvl == pf_lvl)
      else $error("flash level missed eeprom");
   a_no_verify: assert property (@(posedge mclk) disable iff (!rst_n)
      rd_pend_reg && addr_reg == fmlc_pkg::OFF_STATUS |-> hrdata[4:0] == 5'h00)
      else $error("verify flag seen");
   a_out_level: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_en && !addr_is_ee(ahi, p1_reg) |=> ##2 pf_read_level == $past(p2_reg[2:0], 3))
      else $error("applied level not seen by reads");
endmodule : fmlc_margin_cmd
`default_nettype wire

// ---- design/fmlc_pkg.sv ----
/*
 * fmlc_pkg: constants shared by the margin level command block.
 * assumes: 32-bit AHB-Lite register bus, one 40 MHz clock.
 */
package fmlc_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_PARAM0 = 8'h00;
   localparam logic [7:0] OFF_PARAM1 = 8'h04;
   localparam logic [7:0] OFF_PARAM2 = 8'h08;
   localparam logic [7:0] OFF_INDEX = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_MODE = 8'h14;
   localparam logic [7:0] OFF_MARGIN = 8'h18;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
   // status bit positions
   localparam int STAT_CCF = 7;
   localparam int STAT_ACC = 5;
   localparam int STAT_PVIOL = 4;
   localparam int STAT_VHI = 1;
   localparam int STAT_VLO = 0;
   // irq status bit positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   // command codes and fields
   localparam logic [7:0] CMD_USER = 8'h0D;
   localparam logic [7:0] CMD_FIELD = 8'h0E;
   localparam logic [2:0] IDX_REQ = 3'h2;
   localparam logic [15:0] LVL_MAX_USER = 16'h0002;
   localparam logic [15:0] LVL_MAX_FIELD = 16'h0004;
   // block address ranges (upper byte of the 24-bit global address; EE_LO_MAX bounds its low 16 bits)
   localparam logic [7:0] PF_HI_MIN = 8'h80;
   localparam logic [7:0] PF_HI_MAX = 8'hFF;
   localparam logic [7:0] EE_HI = 8'h10;
   localparam logic [15:0] EE_LO_MAX = 16'h07FF;
   // reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [2:0] RST_LEVEL = 3'h0;
   // execution time of a margin command
   localparam int EXEC_NS = 100;
   localparam int CLK_MHZ = 40;
   localparam int EXEC_CYC = (EXEC_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_EXEC, ST_DONE} fmlc_state_t;
endpackage : fmlc_pkg

// ---- verification/test_flash_margin_level_cmd.sv ----
/*
 * test_flash_margin_level_cmd: self-checking bench for the margin level
 * commands, mixing directed corner cases with seeded random commands.
 * assumes: fmlc_pkg and fmlc_margin_cmd compiled first; the bench is the
 * only AHB-Lite master and feeds hreadyout back as hready.
 */
`timescale 1ns/100ps
`default_nettype none
module test_flash_margin_level_cmd;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   wire logic [31:0] hrdata;
   wire logic hreadyout;
   wire logic hresp;
   wire logic [2:0] pf_read_level;
   wire logic [2:0] ee_read_level;
   wire logic irq;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed = 32'hEAB5;
   logic [2:0] pf_m = 3'h0;
   logic [2:0] ee_m = 3'h0;
   logic [31:0] rd;
   logic [31:0] r;

   fmlc_margin_cmd #(.EXEC_CYCLES(4)) dut (.mclk(mclk), .rst_n(rst_n), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pf_read_level(pf_read_level), .ee_read_level(ee_read_level), .irq(irq));

   always #12.5 mclk = ~mclk;

   // a hung handshake ends the run at 20000 cycles, well above the length of a normal run
   always @(posedge mclk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         fails = fails + 1;
         tally_and_finish();
      end
   end

   task tally_and_finish();
      if (fails == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // one single transfer; entered just after a rising edge
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
         @(posedge mclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
         @(posedge mclk);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0, "response");
   endtask : xfer

   function automatic logic cmd_ok(logic [7:0] c, logic [23:0] a, logic [15:0] l,
      logic [2:0] i, logic sp);
      logic blk;
      blk = a[23:16] >= 8'h80 || (a[23:16] == 8'h10 && a[15:0] <= 16'h07FF);
      return i == 3'h2 && blk && ((c == 8'h0D && l <= 16'h0002)
         || (c == 8'h0E && sp && l <= 16'h0004));
   endfunction : cmd_ok

   task run_cmd(input logic [7:0] c, input logic [23:0] a, input logic [15:0] l,
      input logic [2:0] i, input logic sp);
      logic ok;
      int n;
      ok = cmd_ok(c, a, l, i, sp);
      xfer(1'b1, fmlc_pkg::OFF_MODE, {31'h0, sp});
      xfer(1'b1, fmlc_pkg::OFF_PARAM0, {16'h0, c, a[23:16]});
      xfer(1'b1, fmlc_pkg::OFF_PARAM1, {16'h0, a[15:0]});
      xfer(1'b1, fmlc_pkg::OFF_PARAM2, {16'h0, l});
      xfer(1'b1, fmlc_pkg::OFF_INDEX, {29'h0, i});
      xfer(1'b1, fmlc_pkg::OFF_STATUS, 32'h80);
      repeat (2) @(posedge mclk);
      n = 0;
      do
      begin
         xfer(1'b0, fmlc_pkg::OFF_STATUS, 32'h0);
         n++;
      end
      while (rd[7] !== 1'b1 && n < 40);
      check(rd & 32'hB3, ok ? 32'h80 : 32'hA0, "status");
      if (ok && a[23:16] == 8'h10)
         ee_m = l[2:0];
      else if (ok)
         pf_m = l[2:0];
      else
         xfer(1'b1, fmlc_pkg::OFF_STATUS, 32'h20);
      repeat (4) @(posedge mclk);
      check({29'h0, pf_read_level}, {29'h0, pf_m}, "pf level");
      check({29'h0, ee_read_level}, {29'h0, pf_m != 3'h0 ? pf_m : ee_m}, "ee level");
   endtask : run_cmd

   initial
   begin
      repeat (16) @(posedge mclk);
      check({24'h0, hreadyout, irq, pf_read_level, ee_read_level}, 32'h80, "reset outputs");
      rst_n <= 1'b1;
      @(posedge mclk);
      xfer(1'b0, fmlc_pkg::OFF_STATUS, 32'h0);
      check(rd & 32'hB3, 32'h80, "status reset");
      xfer(1'b0, fmlc_pkg::OFF_MARGIN, 32'h0);
      check(rd, 32'h0, "margin reset");
      xfer(1'b1, 8'h24, 32'hFFFF_FFFF);
      xfer(1'b0, 8'h24, 32'h0);
      check(rd, 32'h0, "unmapped");
      xfer(1'b1, fmlc_pkg::OFF_IRQ_MASK, 32'h0);
      // eeprom alone, then flash covering eeprom, then back to normal
      run_cmd(8'h0D, 24'h100000, 16'h0002, 3'h2, 1'b0);
      run_cmd(8'h0D, 24'h800000, 16'h0001, 3'h2, 1'b0);
      run_cmd(8'h0D, 24'h1007FF, 16'h0000, 3'h2, 1'b0);
      run_cmd(8'h0D, 24'hFF0000, 16'h0000, 3'h2, 1'b0);
      run_cmd(8'h0E, 24'h800000, 16'h0003, 3'h2, 1'b0);
      for (int k = 0; k < 5; k++)
         run_cmd(8'h0E, 24'hC00000, 16'(k), 3'h2, 1'b1);
      run_cmd(8'h0E, 24'h100000, 16'h0003, 3'h2, 1'b1);
      // field levels only for the verify pass, then program flash reads back to normal
      run_cmd(8'h0D, 24'h800000, 16'h0000, 3'h2, 1'b0);
      run_cmd(8'h0D, 24'h800000, 16'h0002, 3'h1, 1'b0);
      run_cmd(8'h0D, 24'h800000, 16'h0002, 3'h3, 1'b1);
      run_cmd(8'h0D, 24'h100800, 16'h0001, 3'h2, 1'b0);
      run_cmd(8'h0D, 24'h7F0000, 16'h0001, 3'h2, 1'b0);
      run_cmd(8'h0D, 24'h800000, 16'h0003, 3'h2, 1'b1);
      run_cmd(8'h0E, 24'h800000, 16'h0005, 3'h2, 1'b1);
      run_cmd(8'h0E, 24'h800000, 16'h0104, 3'h2, 1'b1);
      repeat (40)
      begin
         r = $random(seed);
         run_cmd(r[4] ? 8'h0D : 8'h0E, {r[6:5] == 2'h0 ? 8'h10 : r[14:7],
            r[15] ? r[31:16] : {5'h0, r[26:16]}}, {13'h0, r[30:28]},
            r[24:22] == 3'h0 ? 3'h3 : 3'h2, r[19]);
      end
      // interrupt: masked done, then unmasked error, then read clear
      xfer(1'b0, fmlc_pkg::OFF_IRQ_STAT, 32'h0);
      xfer(1'b1, fmlc_pkg::OFF_IRQ_MASK, 32'h2);
      run_cmd(8'h0D, 24'h800000, 16'h0001, 3'h2, 1'b0);
      check({31'h0, irq}, 32'h0, "irq masked");
      xfer(1'b0, fmlc_pkg::OFF_IRQ_STAT, 32'h0);
      check(rd & 32'h3, 32'h1, "irq done only");
      run_cmd(8'h0D, 24'h800000, 16'h0007, 3'h2, 1'b0);
      check({31'h0, irq}, 32'h1, "irq raised");
      xfer(1'b0, fmlc_pkg::OFF_IRQ_STAT, 32'h0);
      check(rd & 32'h3, 32'h3, "irq status");
      repeat (2) @(posedge mclk);
      check({31'h0, irq}, 32'h0, "irq cleared");
      // reset in mid-run returns reads to normal level
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      check({26'h0, pf_read_level, ee_read_level}, 32'h0, "levels after reset");
      rst_n <= 1'b1;
      pf_m = 3'h0;
      ee_m = 3'h0;
      @(posedge mclk);
      // the block must take a full command straight after a second release
      run_cmd(8'h0D, 24'h100000, 16'h0001, 3'h2, 1'b0);
      tally_and_finish();
   end
endmodule : test_flash_margin_level_cmd
`default_nettype wire
